// [scl_fifo.sv]
// Parameterised FIFO that buffers configuration bytes.
`timescale 1ns/10ps
module scl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_i, // System clock.
    input  wire logic             nrst_i,    // Asynchronous reset, active low.
    input  wire logic             in_valid_i, // Write data is valid.
    output logic                  in_ready_o, // FIFO can take a word.
    input  wire logic [WIDTH-1:0] in_data_i,  // Write data.
    output logic                  out_valid_o, // Read data is valid.
    input  wire logic             out_ready_i, // Reader takes the word.
    output logic      [WIDTH-1:0] out_data_o   // Read data.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    // Handshakes qualify each transfer.
    assign in_ready_o  = (count < (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    // Storage is written without reset.
    always_ff @(posedge clk_sys_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (do_rd) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            if (do_wr && !do_rd) begin
                count <= (AW+1)'(count + 1'b1);
            end else if (do_rd && !do_wr) begin
                count <= (AW+1)'(count - 1'b1);
            end
        end
    end
endmodule // scl_fifo

// [scl_pkg.sv]
// Constants of the configuration loader.
package scl_pkg;
    localparam logic [2:0] MODE_SPI      = 3'h1;
    localparam logic [2:0] MODE_PAR      = 3'h6;
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_FAST_READ  = 8'h0B;
    localparam logic [2:0] VS_READ       = 3'h7;
    localparam logic [2:0] VS_FAST       = 3'h5;
    localparam logic [1:0] DUMMY_READ    = 2'h0;
    localparam logic [1:0] DUMMY_FAST    = 2'h1;
    localparam logic [23:0] START_ADDR   = 24'h000000;
    localparam int         FIFO_DEPTH    = 8;
    localparam int         BYTE_W        = 8;
    localparam logic [3:0] DIV_SLOW      = 4'hF;
    localparam logic [3:0] DIV_FAST      = 4'h1;
    localparam logic [5:0] HDR_BITS      = 6'h20;
    localparam logic [4:0] BUSY_LEVEL    = 5'h6;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_HDR   = 5'b00010,
        ST_DUMMY = 5'b00100,
        ST_DATA  = 5'b01000,
        ST_DONE  = 5'b10000
    } scl_state_e;
endpackage

// [scl_loader.sv]
// Configuration loader for SPI master and slave parallel modes.
`timescale 1ns/10ps
module scl_loader (
    input  wire logic       clk_sys_i,           // 25 MHz system clock.
    input  wire logic       nrst_i,              // Async reset, active low.
    input  wire logic       init_status_n_i,     // Init status pin.
    input  wire logic [2:0] config_mode_select_i, // Mode straps.
    input  wire logic [2:0] read_variant_select_i, // Variant straps.
    input  wire logic       pullup_disable_i,    // Pull-up control strap.
    input  wire logic       keep_interface_i,    // Keep-interface option.
    input  wire logic       clock_rate_setting_i, // Bitstream asks fast clock.
    input  wire logic       load_end_i,          // Loader reached end.
    output logic            done_o,              // Configuration done.
    output logic            config_clock_o,      // Generated flash clock.
    output logic            config_clock_oe_n_o, // Clock drive enable, low.
    input  wire logic       config_clock_i,      // Host clock in.
    output logic            mosi_o,              // Flash data input.
    input  wire logic       serial_data_in_pin_i, // Flash data output.
    output logic            chip_select_out_n_o, // Flash or next select.
    output logic            serial_data_out_o,   // Daisy data out.
    input  wire logic [7:0] parallel_data_i,     // Host data byte.
    input  wire logic       chip_select_in_n_i,  // Host select, low.
    input  wire logic       read_write_n_i,      // Host direction, low write.
    output logic            busy_o,              // Not ready for data.
    output logic            pullup_en_o,         // Enable user pull-ups.
    output logic            strap_pins_user_o,   // Straps free as user I/O.
    output logic            par_pins_user_o,     // Port free as user I/O.
    output logic            upper_address_pins_rsv_o, // Upper pins reserved.
    output logic            flash_ctrl_oe_n_o,   // WP/pause drive, low.
    output logic            byte_valid_o,        // Loaded byte valid.
    input  wire logic       byte_ready_i,        // Consumer takes byte.
    output logic [7:0]      byte_data_o          // Loaded byte.
);
    // Two-flop synchronisers for pins.
    logic [1:0] init_s;
    logic [1:0] config_clock_s;
    logic [1:0] din_s;
    logic [1:0] csi_s;
    logic [1:0] rw_s;
    logic [7:0] pd_s1;
    logic [7:0] pd_s2;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic [2:0] vs_s1;
    logic [2:0] vs_s2;
    logic [1:0] pud_s;
    logic       init_q;
    logic       config_clock_q;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            init_s <= 2'h0;
            config_clock_s <= 2'h0;
            din_s  <= 2'h0;
            csi_s  <= 2'h3;
            rw_s   <= 2'h3;
            pd_s1  <= 8'h00;
            pd_s2  <= 8'h00;
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
            vs_s1   <= 3'h0;
            vs_s2   <= 3'h0;
            pud_s   <= 2'h3;
            init_q <= 1'b0;
            config_clock_q <= 1'b0;
        end else begin
            init_s <= {init_s[0], init_status_n_i};
            config_clock_s <= {config_clock_s[0], config_clock_i};
            din_s  <= {din_s[0], serial_data_in_pin_i};
            csi_s  <= {csi_s[0], chip_select_in_n_i};
            rw_s   <= {rw_s[0], read_write_n_i};
            pd_s1  <= parallel_data_i;
            pd_s2  <= pd_s1;
            mode_s1 <= config_mode_select_i;
            mode_s2 <= mode_s1;
            vs_s1   <= read_variant_select_i;
            vs_s2   <= vs_s1;
            pud_s   <= {pud_s[0], pullup_disable_i};
            init_q <= init_s[1];
            config_clock_q <= config_clock_s[1];
        end
    end

    logic init_rise;
    logic config_clock_rise;
    assign init_rise = init_s[1] && !init_q;
    assign config_clock_rise = config_clock_s[1] && !config_clock_q;

    // Strap capture at init_status_n rise.
    logic [2:0] mode;
    logic [2:0] variant;
    logic       started;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode    <= 3'h0;
            variant <= 3'h0;
            started <= 1'b0;
        end else if (init_rise && !started) begin
            mode    <= mode_s2;
            variant <= vs_s2;
            started <= 1'b1;
        end
    end

    logic is_spi;
    logic is_par;
    assign is_spi = started && (mode == scl_pkg::MODE_SPI);
    assign is_par = started && (mode == scl_pkg::MODE_PAR);

    // Variant decode picks opcode and dummy bytes.
    logic [7:0] opcode;
    logic [1:0] dummy_n;
    always_comb begin
        if (variant == scl_pkg::VS_FAST) begin
            opcode  = scl_pkg::OP_FAST_READ;
            dummy_n = scl_pkg::DUMMY_FAST;
        end else begin
            opcode  = scl_pkg::OP_READ;
            dummy_n = scl_pkg::DUMMY_READ;
        end
    end

    // Read state and buffer room, shared by the divider and the sequencer.
    scl_pkg::scl_state_e state;
    logic                fifo_ready;
    logic                spi_run;
    logic                rx_stall;
    assign spi_run  = (state != scl_pkg::ST_IDLE)
                      && (state != scl_pkg::ST_DONE);
    // Holding the clock while the buffer is full keeps the flash from
    // shifting out bits that would have nowhere to go.
    assign rx_stall = (state == scl_pkg::ST_DUMMY
                       || state == scl_pkg::ST_DATA) && !fifo_ready;

    // Clock divider: starts slow, fast if bitstream asks.
    logic [3:0] div_cnt;
    logic       fast;
    logic       sck;
    logic       sck_fall;
    logic       tick;
    assign tick     = (div_cnt == 4'h0);
    assign sck_fall = tick && sck;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= scl_pkg::DIV_SLOW;
            fast    <= 1'b0;
            sck     <= 1'b0;
        end else begin
            if (clock_rate_setting_i) begin
                fast <= 1'b1;
            end
            if (tick) begin
                div_cnt <= fast ? scl_pkg::DIV_FAST : scl_pkg::DIV_SLOW;
                if (!spi_run) begin
                    sck <= 1'b0;
                end else if (!rx_stall) begin
                    sck <= !sck;
                end
            end else begin
                div_cnt <= 4'(div_cnt - 4'h1);
            end
        end
    end

    // SPI read sequencer.
    logic [31:0] shreg;
    logic [5:0]  bit_cnt;
    logic [7:0]  rx;
    logic [2:0]  rx_cnt;
    logic [1:0]  dum_cnt;
    logic        spi_push;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= scl_pkg::ST_IDLE;
            shreg    <= 32'h00000000;
            bit_cnt  <= 6'h00;
            rx       <= 8'h00;
            rx_cnt   <= 3'h0;
            dum_cnt  <= 2'h0;
            spi_push <= 1'b0;
        end else begin
            spi_push <= 1'b0;
            case (state)
                scl_pkg::ST_IDLE: begin
                    if (is_spi) begin
                        shreg   <= {opcode, scl_pkg::START_ADDR};
                        bit_cnt <= scl_pkg::HDR_BITS;
                        dum_cnt <= dummy_n;
                        state   <= scl_pkg::ST_HDR;
                    end
                end
                scl_pkg::ST_HDR: begin
                    if (sck_fall && sck) begin
                        shreg   <= {shreg[30:0], 1'b0};
                        bit_cnt <= 6'(bit_cnt - 6'h01);
                        if (bit_cnt == 6'h01) begin
                            state <= (dum_cnt != 2'h0) ?
                                scl_pkg::ST_DUMMY : scl_pkg::ST_DATA;
                        end
                    end
                end
                scl_pkg::ST_DUMMY, scl_pkg::ST_DATA: begin
                    // Bits are taken as the clock falls, a full period after
                    // the flash drove them, which covers the input's lag.
                    if (load_end_i) begin
                        state <= scl_pkg::ST_DONE;
                    end else if (sck_fall && fifo_ready) begin
                        rx     <= {rx[6:0], din_s[1]};
                        rx_cnt <= 3'(rx_cnt + 3'h1);
                        if (rx_cnt == 3'h7) begin
                            if (state == scl_pkg::ST_DUMMY) begin
                                dum_cnt <= 2'(dum_cnt - 2'h1);
                                if (dum_cnt == 2'h1) begin
                                    state <= scl_pkg::ST_DATA;
                                end
                            end else begin
                                spi_push <= 1'b1;
                            end
                        end
                    end
                end
                scl_pkg::ST_DONE: begin
                    state <= scl_pkg::ST_DONE;
                end
                default: begin
                    state <= scl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Parallel capture on host clock rise.
    logic       par_push;
    logic [7:0] par_byte;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            par_push <= 1'b0;
            par_byte <= 8'h00;
        end else begin
            par_push <= 1'b0;
            if (is_par && !done_o && config_clock_rise && !csi_s[1] && !rw_s[1]
                && fifo_ready) begin
                par_byte <= pd_s2;
                par_push <= 1'b1;
            end
        end
    end

    // Done flag.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
        end else if (started && load_end_i) begin
            done_o <= 1'b1;
        end
    end

    // Byte FIFO between loaders and consumer.
    scl_fifo #(
        .WIDTH (scl_pkg::BYTE_W),
        .DEPTH (scl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (spi_push || par_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (par_push ? par_byte : rx),
        .out_valid_o (byte_valid_o),
        .out_ready_i (byte_ready_i),
        .out_data_o  (byte_data_o)
    );

    // Pin drive and pin roles.
    assign config_clock_o      = sck;
    assign config_clock_oe_n_o = !(is_spi && !done_o);
    assign mosi_o              = shreg[31];
    assign chip_select_out_n_o = !(is_spi && (state != scl_pkg::ST_IDLE)
                                 && (state != scl_pkg::ST_DONE));
    assign serial_data_out_o   = din_s[1];
    assign busy_o              = is_par && !fifo_ready;
    assign pullup_en_o         = !done_o && !pud_s[1];
    assign strap_pins_user_o   = done_o;
    assign par_pins_user_o     = done_o && !keep_interface_i;
    assign upper_address_pins_rsv_o = !done_o || keep_interface_i;
    assign flash_ctrl_oe_n_o   = 1'b1;
endmodule // scl_loader

// [scl_loader_asserts.sv]
// Concurrent checks on the configuration loader's ports.
`timescale 1ns/10ps
module scl_loader_chk (
    input wire logic clk_sys_i,                // Clock.
    input wire logic nrst_i,                   // Reset, low.
    input wire logic pullup_disable_i,         // Pull-up strap.
    input wire logic keep_interface_i,         // Keep option.
    input wire logic clock_rate_setting_i,     // Fast clock request.
    input wire logic done_o,                   // Done.
    input wire logic config_clock_o,           // Flash clock.
    input wire logic config_clock_oe_n_o,      // Clock enable, low.
    input wire logic chip_select_out_n_o,      // Select out.
    input wire logic busy_o,                   // Busy.
    input wire logic byte_valid_o,             // Byte valid.
    input wire logic pullup_en_o,              // Pull-ups on.
    input wire logic strap_pins_user_o,        // Straps free.
    input wire logic par_pins_user_o,          // Port free.
    input wire logic upper_address_pins_rsv_o, // Upper pins kept.
    input wire logic flash_ctrl_oe_n_o         // Flash controls off.
);
    logic fast_seen; // Fast clock was asked for.
    // Remember a request for the fast clock until the next reset.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) fast_seen <= 1'b0;
        else if (clock_rate_setting_i) fast_seen <= 1'b1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wp_pause_off_a: assert property (flash_ctrl_oe_n_o)
        else $error("flash controls driven");
    busy_full_a: assert property (busy_o |-> byte_valid_o)
        else $error("busy without full buffer");
    done_sticky_a: assert property (done_o |=> done_o)
        else $error("done dropped");
    strap_user_a: assert property (strap_pins_user_o == done_o)
        else $error("strap release wrong");
    pullup_ctl_a: assert property (
        (!done_o && $stable(pullup_disable_i)) [*3]
        |-> pullup_en_o != pullup_disable_i)
        else $error("pull-up control wrong");
    par_user_a: assert property (
        par_pins_user_o == (done_o && !keep_interface_i))
        else $error("port release wrong");
    upper_rsv_a: assert property (
        done_o && keep_interface_i |-> upper_address_pins_rsv_o)
        else $error("upper pins not kept");
    done_quiet_a: assert property (
        done_o |-> chip_select_out_n_o && config_clock_oe_n_o)
        else $error("flash still driven after done");
    slow_start_a: assert property (
        $rose(config_clock_o) && !fast_seen
        |=> (config_clock_o || fast_seen) [*8])
        else $error("clock too fast at start");
endmodule // scl_loader_chk
bind scl_loader scl_loader_chk chk_u (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .done_o(done_o),
    .pullup_disable_i(pullup_disable_i), .busy_o(busy_o),
    .keep_interface_i(keep_interface_i), .byte_valid_o(byte_valid_o),
    .clock_rate_setting_i(clock_rate_setting_i),
    .config_clock_o(config_clock_o), .pullup_en_o(pullup_en_o),
    .config_clock_oe_n_o(config_clock_oe_n_o),
    .chip_select_out_n_o(chip_select_out_n_o),
    .strap_pins_user_o(strap_pins_user_o),
    .par_pins_user_o(par_pins_user_o),
    .upper_address_pins_rsv_o(upper_address_pins_rsv_o),
    .flash_ctrl_oe_n_o(flash_ctrl_oe_n_o));

// [scl_flash_model.sv]
// Behavioural serial flash that answers the loader's read command.
`timescale 1ns/10ps
module scl_flash_model (
    input  wire logic        sck_i,  // Serial clock.
    input  wire logic        cs_n_i, // Select, low.
    input  wire logic        mosi_i, // Command bits.
    output logic             miso_o, // Read data.
    output logic [31:0]      hdr_o   // Opcode and address seen.
);
    int         nbit; // Clocks in this frame.
    int         pos;  // Data bit position.
    logic [7:0] dat;  // Byte being sent.
    // Pause and write protect inputs are taken as tied high.
    initial begin
        nbit = 0;
        miso_o = 1'b0;
        hdr_o = '0;
    end
    // Capture opcode and address MSB first while selected.
    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            if (nbit < 32) hdr_o <= {hdr_o[30:0], mosi_i};
            nbit <= nbit + 1;
        end
    end
    // A released line toggles so that stale data cannot pass.
    always @(posedge cs_n_i) begin
        nbit <= 0;
        miso_o <= ~miso_o;
    end
    // Send bytes after the header and the fast read dummy byte.
    always @(negedge sck_i) begin
        if (!cs_n_i) begin
            pos = nbit - ((hdr_o[31:24] == 8'h0B) ? 40 : 32);
            dat = 8'(pos / 8) * 8'h1D + 8'h3C;
            miso_o <= (pos < 0) ? ~miso_o : dat[7 - pos % 8];
        end
    end
endmodule // scl_flash_model

// [tb_scl_loader.sv]
// Self-checking bench of the configuration loader.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    err_total++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module tb_scl_loader;
    logic        clk_sys_i, nrst_i, init_n, pud, keep, rate, load_end;
    logic        config_clock_in, csi_n, rw_n, rdy, hold_rdy, miso, busy, done;
    logic        config_clock, config_clock_oe_n, mosi, cso_n, pu_en, s_user, p_user, up_rsv;
    logic        sdo, fc_oe_n;
    logic [2:0]  mode, variant;
    logic [7:0]  pdata, exp_b, bdata;
    logic        bvalid;
    logic [31:0] hdr, lfsr, exp_hdr;
    logic [7:0]  exp_q[$];
    logic [2:0]  vs_tab[2] = '{3'h5, 3'h7};
    int          err_total, n_checks, rx_cnt;
    scl_loader dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .init_status_n_i(init_n), .config_mode_select_i(mode),
        .read_variant_select_i(variant), .pullup_disable_i(pud),
        .keep_interface_i(keep), .clock_rate_setting_i(rate),
        .load_end_i(load_end), .done_o(done), .config_clock_o(config_clock),
        .config_clock_oe_n_o(config_clock_oe_n), .config_clock_i(config_clock_in),
        .mosi_o(mosi), .serial_data_in_pin_i(miso), .serial_data_out_o(sdo),
        .chip_select_out_n_o(cso_n), .parallel_data_i(pdata),
        .chip_select_in_n_i(csi_n), .read_write_n_i(rw_n), .busy_o(busy),
        .pullup_en_o(pu_en), .strap_pins_user_o(s_user),
        .par_pins_user_o(p_user), .upper_address_pins_rsv_o(up_rsv),
        .flash_ctrl_oe_n_o(fc_oe_n), .byte_valid_o(bvalid),
        .byte_ready_i(rdy), .byte_data_o(bdata));
    scl_flash_model flash_u (.sck_i(config_clock), .cs_n_i(cso_n), .mosi_i(mosi),
        .miso_o(miso), .hdr_o(hdr));
    // Free-running system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up;
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset, present the straps, then raise init.
    task automatic start(input logic [2:0] m, v, input logic pd, kp);
        nrst_i = 1'b0;
        init_n = 1'b0;
        load_end = 1'b0;
        rate = 1'b0;
        rx_cnt = 0;
        tick(4);
        nrst_i = 1'b1;
        mode = m;
        variant = v;
        pud = pd;
        keep = kp;
        tick(3);
        init_n = 1'b1;
        tick(8);
        `CHK("pull-ups", ~pd, pu_en)
    endtask
    task automatic wait_rx(input int n);
        for (int w = 0; w < 20000 && rx_cnt < n; w++) tick(1);
        `CHK("bytes", n, rx_cnt)
    endtask
    task automatic finish_load(input logic kp);
        load_end = 1'b1;
        tick(1);
        load_end = 1'b0;
        tick(4);
        `CHK("done", 1'b1, done)
        `CHK("strap user", 1'b1, s_user)
        `CHK("port user", ~kp, p_user)
        `CHK("select idle", 1'b1, cso_n)
        `CHK("flash controls", 1'b1, fc_oe_n)
        `CHK("data out", miso, sdo)
    endtask
    // Host presents a byte and clocks it in once not busy, or after 50 waits of 8 cycles if busy stays high.
    task automatic par_byte;
        pdata = lfsr[15:8];
        tick(4);
        for (int w = 0; w < 50 && busy === 1'b1; w++) tick(8);
        exp_q.push_back(pdata);
        config_clock_in = 1'b1;
        tick(4);
        config_clock_in = 1'b0;
    endtask
    // Consumer takes bytes at random while results are owed.
    always @(posedge clk_sys_i) begin
        #1;
        lfsr = lfsr_next(lfsr);
        rdy = !hold_rdy && exp_q.size() > 0 && lfsr[0];
    end
    // Take the oldest note whenever a byte is handed over.
    always @(posedge clk_sys_i) begin
        if (bvalid === 1'b1 && rdy === 1'b1 && exp_q.size() > 0) begin
            exp_b = exp_q.pop_front();
            `CHK("byte", exp_b, bdata)
            rx_cnt++;
        end
    end
    // Cut a hang short.
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        err_total++;
        wrap_up();
    end
    // Two serial reads, then one parallel load.
    initial begin
        err_total = 0;
        n_checks = 0;
        lfsr = 32'h793717D8;
        {hold_rdy, rdy, config_clock_in, csi_n, rw_n} = 5'h03;
        {pdata, mode, variant, pud, keep} = '0;
        foreach (vs_tab[i]) begin
            start(scl_pkg::MODE_SPI, vs_tab[i], i == 1, 1'b0);
            for (int k = 0; k < 12; k++)
                exp_q.push_back(8'(k) * 8'h1D + 8'h3C);
            `CHK("clock drive", 1'b0, config_clock_oe_n)
            `CHK("select", 1'b0, cso_n)
            wait_rx(4);
            rate = (i == 1);
            wait_rx(12);
            exp_hdr = {(i == 0) ? scl_pkg::OP_FAST_READ : scl_pkg::OP_READ,
                       scl_pkg::START_ADDR};
            `CHK("header", exp_hdr, hdr)
            finish_load(1'b0);
        end
        {csi_n, rw_n, hold_rdy} = 3'h1;
        start(scl_pkg::MODE_PAR, 3'h7, 1'b1, 1'b1);
        fork
            for (int k = 0; k < 20; k++) par_byte();
            begin
                for (int w = 0; w < 400 && busy !== 1'b1; w++) tick(1);
                `CHK("busy when full", 1'b1, busy)
                `CHK("held bytes", 8, exp_q.size())
                tick(24);
                hold_rdy = 1'b0;
            end
        join
        wait_rx(20);
        finish_load(1'b1);
        `CHK("upper pins", 1'b1, up_rsv)
        wrap_up();
    end
endmodule // tb_scl_loader
